// ### rtl/vccr_pkg.sv
// Purpose: Shared constants and carriers for the codec control register bank.
// Assumes: Registers are eight bits wide and addressed by a 5-bit index.
// Notes:   Registers 7 and 9 are held as plain storage with fixed reserved masks; 8 is read-only short status.
package vccr_pkg;

   // ==========================================================================
   // Register addresses
   localparam logic [4:0] ADDR_ZERO     = 5'h00;
   localparam logic [4:0] ADDR_CTRL_ONE = 5'h01;
   localparam logic [4:0] ADDR_CTRL_TWO = 5'h02;
   localparam logic [4:0] ADDR_PLL_DIV  = 5'h03;
   localparam logic [4:0] ADDR_PLL_MUL  = 5'h04;
   localparam logic [4:0] ADDR_RX_GAIN  = 5'h05;
   localparam logic [4:0] ADDR_ADC_VOL  = 5'h06;
   localparam logic [4:0] ADDR_DAC_VOL  = 5'h07;
   localparam logic [4:0] ADDR_SHORT    = 5'h08;
   localparam logic [4:0] ADDR_ATTEN    = 5'h09;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] RST_CTRL_ONE = 8'h00;
   localparam logic [7:0] RST_CTRL_TWO = 8'h00;
   localparam logic [7:0] RST_PLL_DIV  = 8'h00;
   localparam logic [7:0] RST_PLL_MUL  = 8'h00;
   localparam logic [7:0] RST_RX_GAIN  = 8'h47;
   localparam logic [7:0] RST_ADC_VOL  = 8'h5C;
   localparam logic [7:0] RST_DAC_VOL  = 8'h5C;
   localparam logic [7:0] RST_ATTEN    = 8'h00;

   // ==========================================================================
   // Writable-bit masks, and the status-bit mask of read-only register 8; reserved positions are zero
   localparam logic [7:0] MASK_CTRL_ONE = 8'h1F;
   localparam logic [7:0] MASK_CTRL_TWO = 8'h1E;
   localparam logic [7:0] MASK_FULL     = 8'hFF;
   localparam logic [7:0] MASK_VOL      = 8'h7F;
   localparam logic [7:0] MASK_ATTEN    = 8'h0F;
   localparam logic [7:0] MASK_SHORT    = 8'hE0;

   // ==========================================================================
   // Field positions
   localparam int BIT_SOFT_RESET  = 7;
   localparam int BIT_SPEAKER_ON  = 4;
   localparam int BIT_LINE_ON     = 3;
   localparam int BIT_HANDSET_ON  = 2;
   localparam int BIT_MIC_BIAS    = 1;
   localparam int BIT_CHIP_SLEEP  = 0;
   localparam int BIT_HIGHPASS    = 4;
   localparam int BIT_PLL_TEN     = 3;
   localparam int BIT_ANALOG_LOOP = 2;
   localparam int BIT_STREAM_LOOP = 1;
   localparam int BIT_LINE_MUTE   = 5;
   localparam int BIT_MIC_MUTE    = 2;
   localparam int BIT_HS_MUTE     = 1;
   localparam int BIT_IIR         = 0;
   localparam int BIT_LINE_OUT    = 1;
   localparam int BIT_HS_OUT      = 0;
   localparam int BIT_SPK_LEFT    = 1;
   localparam int BIT_SPK_RIGHT   = 0;

   // ==========================================================================
   // PLL final-stage divide figures
   localparam logic [3:0] PLL_DIV_TEN  = 4'hA;
   localparam logic [3:0] PLL_DIV_FIVE = 4'h5;

   // ==========================================================================
   // Carriers
   typedef struct packed {
      logic       valid;
      logic       read;
      logic [4:0] addr;
      logic [7:0] wdata;
   } vccr_access_s;

   typedef struct packed {
      logic       speaker_drive_on;
      logic       line_drive_on;
      logic       handset_drive_on;
      logic       mic_bias_off;
      logic       chip_sleep;
      logic       highpass_off;
      logic [3:0] pll_final_div;
      logic       analog_loopback;
      logic       bitstream_loopback;
      logic [8:0] pll_divider_value;
      logic [8:0] pll_multiplier_value;
      logic       pll_bypass;
      logic [4:0] line_in_gain_db;
      logic       line_in_mute;
      logic [4:0] mic_gain_db;
      logic       mic_mute;
      logic       handset_in_mute;
      logic       iir_select;
      logic [4:0] receive_gain;
      logic       line_out_mute;
      logic       handset_out_mute;
      logic [4:0] transmit_gain;
      logic       left_speaker_mute;
      logic       right_speaker_mute;
      logic [1:0] line_out_atten;
   } vccr_ctrl_s;

   typedef struct packed {
      logic [7:0] ctrl_one;
      logic [7:0] ctrl_two;
      logic [7:0] pll_div;
      logic [7:0] pll_mul;
      logic [7:0] rx_gain;
      logic [7:0] adc_vol;
      logic [7:0] dac_vol;
      logic [7:0] atten;
   } vccr_regs_s;

endpackage : vccr_pkg

// ### rtl/vccr_decode.sv
// Purpose: Turns stored register fields into the controls the analog side uses.
// Assumes: Inputs are registered values on CLK_SYS.
// Notes:   Registered output so every top output comes from a flip-flop.
`timescale 1ns/10ps
module vccr_decode (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire vccr_pkg::vccr_regs_s regs,
   output vccr_pkg::vccr_ctrl_s      ctrl
);

   // ==========================================================================
   // Decode
   typedef struct packed {
      vccr_pkg::vccr_ctrl_s ctrl;
   } vccr_dec_state_s;

   vccr_dec_state_s st_q;
   vccr_dec_state_s st_d;

   always_comb begin
      st_d = st_q;
      st_d.ctrl.speaker_drive_on   = regs.ctrl_one[vccr_pkg::BIT_SPEAKER_ON];
      st_d.ctrl.line_drive_on      = regs.ctrl_one[vccr_pkg::BIT_LINE_ON];
      st_d.ctrl.handset_drive_on   = regs.ctrl_one[vccr_pkg::BIT_HANDSET_ON];
      st_d.ctrl.mic_bias_off       = regs.ctrl_one[vccr_pkg::BIT_MIC_BIAS];
      st_d.ctrl.chip_sleep         = regs.ctrl_one[vccr_pkg::BIT_CHIP_SLEEP];
      st_d.ctrl.highpass_off       = regs.ctrl_two[vccr_pkg::BIT_HIGHPASS];
      st_d.ctrl.pll_final_div      = regs.ctrl_two[vccr_pkg::BIT_PLL_TEN] ?
                                     vccr_pkg::PLL_DIV_TEN : vccr_pkg::PLL_DIV_FIVE;
      st_d.ctrl.analog_loopback    = regs.ctrl_two[vccr_pkg::BIT_ANALOG_LOOP];
      st_d.ctrl.bitstream_loopback = regs.ctrl_two[vccr_pkg::BIT_STREAM_LOOP];
      st_d.ctrl.pll_divider_value    = {1'b0, regs.pll_div} + 9'h001;
      st_d.ctrl.pll_multiplier_value = {1'b0, regs.pll_mul} + 9'h001;
      st_d.ctrl.pll_bypass = (regs.pll_div == 8'h00) && (regs.pll_mul == 8'h00);
      unique case (regs.rx_gain[7:6])
         2'h3:    st_d.ctrl.line_in_gain_db = 5'h14;
         2'h2:    st_d.ctrl.line_in_gain_db = 5'h0A;
         default: st_d.ctrl.line_in_gain_db = 5'h00;
      endcase
      st_d.ctrl.line_in_mute    = regs.rx_gain[vccr_pkg::BIT_LINE_MUTE];
      // Widened before the product so that code 11 gives 30 without wrapping.
      st_d.ctrl.mic_gain_db     = {3'h0, regs.rx_gain[4:3]} * 5'h0A;
      st_d.ctrl.mic_mute        = regs.rx_gain[vccr_pkg::BIT_MIC_MUTE];
      st_d.ctrl.handset_in_mute = regs.rx_gain[vccr_pkg::BIT_HS_MUTE];
      st_d.ctrl.iir_select      = regs.rx_gain[vccr_pkg::BIT_IIR];
      st_d.ctrl.receive_gain    = regs.adc_vol[6:2];
      st_d.ctrl.line_out_mute   = ~regs.adc_vol[vccr_pkg::BIT_LINE_OUT];
      st_d.ctrl.handset_out_mute   = ~regs.adc_vol[vccr_pkg::BIT_HS_OUT];
      st_d.ctrl.transmit_gain      = regs.dac_vol[6:2];
      st_d.ctrl.left_speaker_mute  = ~regs.dac_vol[vccr_pkg::BIT_SPK_LEFT];
      st_d.ctrl.right_speaker_mute = ~regs.dac_vol[vccr_pkg::BIT_SPK_RIGHT];
      st_d.ctrl.line_out_atten     = regs.atten[3:2];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign ctrl = st_q.ctrl;

   // This stage is still held in reset on the edge that releases it, so that edge starts no check.
   chk_pll_bypass_follows: assert property (@(posedge clk) disable iff (rst)
      (!rst && regs.pll_div == 8'h00 && regs.pll_mul == 8'h00) |=> ctrl.pll_bypass)
      else $error("PLL bypass did not follow zero divider and multiplier.");

   chk_pll_plus_one: assert property (@(posedge clk) disable iff (rst)
      !rst |=> ctrl.pll_divider_value == {1'b0, $past(regs.pll_div)} + 9'h001)
      else $error("PLL divider value is not stored value plus one.");

endmodule // vccr_decode

// ### rtl/vccr_bank.sv
// Purpose: Control register bank of a voiceband codec, reached one access per frame.
// Assumes: The serial framer delivers each access as a one-cycle request on CLK_SYS.
// Notes:   Read data is registered and valid one cycle after the request.
//
// ============================================================================
// Overview of operation
// - Address zero reads zero; writes to it change nothing.
// - Writing one to soft reset restores all registers; bit self-clears.
// - Speaker drive bit low powers down both speaker drivers.
// - Line and handset drive bits low power down their drivers.
// - Mic bias bit high powers down the bias buffer.
// - Chip sleep bit high puts the device in low-power mode.
// - High-pass disable bit high turns the filter off.
// - PLL final stage divides by ten when set, five when clear.
// - Analog loopback routes DAC output into ADC input.
// - Bitstream loopback routes one-bit DAC stream into ADC stream.
// - PLL divider and multiplier registers hold value minus one.
// - Line mute bit high mutes line input, low routes it.
// - Mic and handset mute bits high mute, low route to mixer.
// - Filter select bit high picks IIR, low picks FIR.
// - Receive gain field steps 1.5 dB, 10111 is 0 dB.
// - One access per frame: read flag, 5-bit address, data.
// - Divider and multiplier both zero bypass the PLL.
`timescale 1ns/10ps
module vccr_bank (
   input  wire logic                   CLK_SYS,
   input  wire logic                   RST,
   input  wire vccr_pkg::vccr_access_s ACCESS,
   input  wire logic [2:0]             SHORT_FLAGS,
   output vccr_pkg::vccr_ctrl_s        CTRL,
   output logic [7:0]                  READ_DATA,
   output logic                        READ_VALID
);

   // ==========================================================================
   // State
   typedef struct packed {
      vccr_pkg::vccr_regs_s regs;
      logic [2:0]           short_meta;
      logic [2:0]           short_sync;
      logic [7:0]           rdata;
      logic                 rvalid;
   } vccr_state_s;

   vccr_state_s st_q;
   vccr_state_s st_d;

   function automatic vccr_pkg::vccr_regs_s reset_regs();
      vccr_pkg::vccr_regs_s r;
      r.ctrl_one = vccr_pkg::RST_CTRL_ONE;
      r.ctrl_two = vccr_pkg::RST_CTRL_TWO;
      r.pll_div  = vccr_pkg::RST_PLL_DIV;
      r.pll_mul  = vccr_pkg::RST_PLL_MUL;
      r.rx_gain  = vccr_pkg::RST_RX_GAIN;
      r.adc_vol  = vccr_pkg::RST_ADC_VOL;
      r.dac_vol  = vccr_pkg::RST_DAC_VOL;
      r.atten    = vccr_pkg::RST_ATTEN;
      return r;
   endfunction

   // ==========================================================================
   // Access handling
   // The short-circuit flags come from analog comparators, so they are synchronised first.
   always_comb begin
      st_d            = st_q;
      st_d.short_meta = SHORT_FLAGS;
      st_d.short_sync = st_q.short_meta;
      st_d.rvalid     = 1'b0;
      if (ACCESS.valid && ACCESS.read) begin
         st_d.rvalid = 1'b1;
         unique case (ACCESS.addr)
            vccr_pkg::ADDR_CTRL_ONE: st_d.rdata = st_q.regs.ctrl_one;
            vccr_pkg::ADDR_CTRL_TWO: st_d.rdata = st_q.regs.ctrl_two;
            vccr_pkg::ADDR_PLL_DIV:  st_d.rdata = st_q.regs.pll_div;
            vccr_pkg::ADDR_PLL_MUL:  st_d.rdata = st_q.regs.pll_mul;
            vccr_pkg::ADDR_RX_GAIN:  st_d.rdata = st_q.regs.rx_gain;
            vccr_pkg::ADDR_ADC_VOL:  st_d.rdata = st_q.regs.adc_vol;
            vccr_pkg::ADDR_DAC_VOL:  st_d.rdata = st_q.regs.dac_vol;
            vccr_pkg::ADDR_SHORT:    st_d.rdata = {st_q.short_sync, 5'h00};
            vccr_pkg::ADDR_ATTEN:    st_d.rdata = st_q.regs.atten;
            default:                 st_d.rdata = 8'h00;
         endcase
      end
      if (ACCESS.valid && !ACCESS.read) begin
         // Reserved bits are masked on write, so they always read back as zero.
         unique case (ACCESS.addr)
            vccr_pkg::ADDR_CTRL_ONE: begin
               if (ACCESS.wdata[vccr_pkg::BIT_SOFT_RESET]) begin
                  st_d.regs = reset_regs();
               end else begin
                  st_d.regs.ctrl_one = ACCESS.wdata & vccr_pkg::MASK_CTRL_ONE;
               end
            end
            vccr_pkg::ADDR_CTRL_TWO:
               st_d.regs.ctrl_two = ACCESS.wdata & vccr_pkg::MASK_CTRL_TWO;
            vccr_pkg::ADDR_PLL_DIV:  st_d.regs.pll_div = ACCESS.wdata;
            vccr_pkg::ADDR_PLL_MUL:  st_d.regs.pll_mul = ACCESS.wdata;
            vccr_pkg::ADDR_RX_GAIN:  st_d.regs.rx_gain = ACCESS.wdata;
            vccr_pkg::ADDR_ADC_VOL:
               st_d.regs.adc_vol = ACCESS.wdata & vccr_pkg::MASK_VOL;
            vccr_pkg::ADDR_DAC_VOL:
               st_d.regs.dac_vol = ACCESS.wdata & vccr_pkg::MASK_VOL;
            vccr_pkg::ADDR_ATTEN:
               st_d.regs.atten = ACCESS.wdata & vccr_pkg::MASK_ATTEN;
            // Address zero and unlisted addresses are dropped without effect.
            default: st_d.regs = st_q.regs;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         st_q.regs       <= '0;
         st_q.regs.rx_gain <= vccr_pkg::RST_RX_GAIN;
         st_q.regs.adc_vol <= vccr_pkg::RST_ADC_VOL;
         st_q.regs.dac_vol <= vccr_pkg::RST_DAC_VOL;
         st_q.short_meta <= '0;
         st_q.short_sync <= '0;
         st_q.rdata      <= '0;
         st_q.rvalid     <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================================
   // Field decode
   vccr_decode u_decode (
      .clk  (CLK_SYS),
      .rst  (RST),
      .regs (st_q.regs),
      .ctrl (CTRL)
   );

   assign READ_DATA  = st_q.rdata;
   assign READ_VALID = st_q.rvalid;

   // ==========================================================================
   // Checks
   chk_zero_reads_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ACCESS.valid && ACCESS.read && ACCESS.addr == vccr_pkg::ADDR_ZERO)
      |=> (READ_VALID && READ_DATA == 8'h00))
      else $error("Address zero did not read as zero.");

   chk_zero_write_inert: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ACCESS.valid && !ACCESS.read && ACCESS.addr == vccr_pkg::ADDR_ZERO)
      |=> $stable(st_q.regs))
      else $error("Write to address zero changed a register.");

   chk_soft_reset_all: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ACCESS.valid && !ACCESS.read && ACCESS.addr == vccr_pkg::ADDR_CTRL_ONE
       && ACCESS.wdata[7])
      |=> (st_q.regs.ctrl_one == 8'h00 && st_q.regs.rx_gain == 8'h47
           && st_q.regs.adc_vol == 8'h5C && st_q.regs.pll_div == 8'h00))
      else $error("Soft reset did not restore reset values.");

   chk_soft_reset_clears: assert property (@(posedge CLK_SYS) disable iff (RST)
      st_q.regs.ctrl_one[7] == 1'b0)
      else $error("Soft reset bit did not clear itself.");

   chk_speaker_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
      1'b1 |=> CTRL.speaker_drive_on == $past(st_q.regs.ctrl_one[4]))
      else $error("Speaker drive does not follow its control bit.");

   chk_mic_bias_off: assert property (@(posedge CLK_SYS) disable iff (RST)
      1'b1 |=> CTRL.mic_bias_off == $past(st_q.regs.ctrl_one[1]))
      else $error("Mic bias power-down does not follow its bit.");

   chk_pll_final_div: assert property (@(posedge CLK_SYS) disable iff (RST)
      st_q.regs.ctrl_two[3] |=> CTRL.pll_final_div == 4'hA)
      else $error("PLL final stage is not divide by ten.");

   chk_line_gain_map: assert property (@(posedge CLK_SYS) disable iff (RST)
      (st_q.regs.rx_gain[7:6] == 2'h3) |=> CTRL.line_in_gain_db == 5'h14)
      else $error("Line gain code 11 did not give 20 dB.");

   chk_mic_gain_map: assert property (@(posedge CLK_SYS) disable iff (RST)
      (st_q.regs.rx_gain[4:3] == 2'h3) |=> CTRL.mic_gain_db == 5'h1E)
      else $error("Mic gain code 11 did not give 30 dB.");

   chk_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
      (st_q.regs.ctrl_two[0] == 1'b0 && st_q.regs.ctrl_one[6:5] == 2'h0
       && st_q.regs.adc_vol[7] == 1'b0))
      else $error("A reserved bit is set.");

   chk_read_one_cycle: assert property (@(posedge CLK_SYS) disable iff (RST)
      (ACCESS.valid && ACCESS.read)
      |=> READ_VALID ##1 (READ_VALID == $past(ACCESS.valid && ACCESS.read)))
      else $error("Read answer timing wrong.");

endmodule // vccr_bank

// ### test/vccr_host_model.sv
// Purpose: Host model that issues one register access per frame to the bank.
// Assumes: The bank takes a request on the rising clock edge while valid is high.
// Notes:   Reserved bits are cleared on writes unless a caller asks for a raw write.
`timescale 1ns/10ps
module vccr_host_model (
   input  wire logic              clk,
   output vccr_pkg::vccr_access_s access,
   input  wire logic [7:0]        read_data,
   input  wire logic              read_valid
);
   // =========================================================================
   // Access tasks
   initial access = '0;

   function automatic logic [7:0] host_mask(input logic [4:0] a);
      case (a)
         vccr_pkg::ADDR_CTRL_ONE: host_mask = 8'h9F;
         vccr_pkg::ADDR_CTRL_TWO: host_mask = vccr_pkg::MASK_CTRL_TWO;
         vccr_pkg::ADDR_ADC_VOL,
         vccr_pkg::ADDR_DAC_VOL:  host_mask = vccr_pkg::MASK_VOL;
         vccr_pkg::ADDR_ATTEN:    host_mask = vccr_pkg::MASK_ATTEN;
         default:                 host_mask = vccr_pkg::MASK_FULL;
      endcase
   endfunction

   // Callers only pass defined addresses.
   task automatic write_reg(input logic [4:0] a, input logic [7:0] d, input bit raw);
      @(posedge clk);
      access <= '{valid: 1'b1, read: 1'b0, addr: a, wdata: raw ? d : (d & host_mask(a))};
      @(posedge clk);
      // A released port shows inverted leftovers, never a stale request.
      access <= {1'b0, ~access[13:0]};
   endtask

   task automatic read_reg(input logic [4:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      access <= '{valid: 1'b1, read: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      access <= {1'b0, ~access[13:0]};
      @(negedge clk);
      v = read_valid;
      d = read_data;
   endtask
endmodule // vccr_host_model

// ### test/vccr_bank_test.sv
// Purpose: Self-checking bench for the codec control register bank.
// Assumes: Read data lands one cycle after the request, controls two after a write.
// Notes:   Short flags are held steady so the status register is predictable.
`timescale 1ns/10ps
module vccr_bank_test;
   logic                   clk_sys;
   logic                   rst;
   logic [2:0]             short_flags;
   vccr_pkg::vccr_access_s access;
   vccr_pkg::vccr_ctrl_s   ctrl;
   logic [7:0]             read_data;
   logic                   read_valid;
   int                     num_errors = 0;
   int                     n_compared = 0;
   int                     cycles = 0;
   logic [7:0]             rd;
   logic                   rv;
   logic [7:0]             d;

   vccr_bank u_vccr_bank (.CLK_SYS(clk_sys), .RST(rst), .ACCESS(access),
      .SHORT_FLAGS(short_flags), .CTRL(ctrl), .READ_DATA(read_data), .READ_VALID(read_valid));
   vccr_host_model u_vccr_host_model (.clk(clk_sys), .access(access), .read_data(read_data),
      .read_valid(read_valid));

   // =========================================================================
   // Clock, timeout and reporting
   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // =========================================================================
   // Access helpers
   // Waits out the two-cycle lag so the decoded controls can be compared.
   task automatic wr(input logic [4:0] a, input logic [7:0] v, input bit raw = 1'b0);
      u_vccr_host_model.write_reg(a, v, raw);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      u_vccr_host_model.read_reg(a, rd, rv);
      chk({15'h0000, rv}, 16'h0001);
      chk({8'h00, rd}, {8'h00, exp});
   endtask

   function automatic logic [7:0] reset_value(input logic [4:0] a);
      case (a)
         vccr_pkg::ADDR_RX_GAIN: reset_value = vccr_pkg::RST_RX_GAIN;
         vccr_pkg::ADDR_ADC_VOL: reset_value = vccr_pkg::RST_ADC_VOL;
         vccr_pkg::ADDR_DAC_VOL: reset_value = vccr_pkg::RST_DAC_VOL;
         vccr_pkg::ADDR_SHORT:   reset_value = {short_flags, 5'h00};
         default:                reset_value = 8'h00;
      endcase
   endfunction

   task automatic check_defaults();
      for (int a = 0; a < 10; a++) begin
         rd_chk(a[4:0], reset_value(a[4:0]));
      end
      rd_chk(5'h1F, 8'h00);
      chk({15'h0000, ctrl.pll_bypass}, 16'h0001);
      chk({11'h000, ctrl.speaker_drive_on, ctrl.line_drive_on, ctrl.handset_drive_on,
         ctrl.mic_bias_off, ctrl.chip_sleep}, 16'h0000);
   endtask

   // =========================================================================
   // Test sequence
   initial begin
      rst = 1'b1;
      short_flags = 3'b101;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      check_defaults();
      $display("test reset_values done");

      wr(5'h01, 8'h7F, 1'b1);
      rd_chk(5'h01, 8'h1F);
      wr(5'h01, 8'h15);
      chk({11'h000, ctrl.speaker_drive_on, ctrl.line_drive_on, ctrl.handset_drive_on,
         ctrl.mic_bias_off, ctrl.chip_sleep}, 16'h0015);
      wr(5'h01, 8'h0A);
      chk({11'h000, ctrl.speaker_drive_on, ctrl.line_drive_on, ctrl.handset_drive_on,
         ctrl.mic_bias_off, ctrl.chip_sleep}, 16'h000A);
      $display("test power_controls done");

      wr(5'h02, 8'hFF, 1'b1);
      rd_chk(5'h02, 8'h1E);
      chk({9'h000, ctrl.highpass_off, ctrl.pll_final_div, ctrl.analog_loopback,
         ctrl.bitstream_loopback}, {9'h000, 1'b1, vccr_pkg::PLL_DIV_TEN, 2'b11});
      wr(5'h02, 8'h12);
      chk({9'h000, ctrl.highpass_off, ctrl.pll_final_div, ctrl.analog_loopback,
         ctrl.bitstream_loopback}, {9'h000, 1'b1, vccr_pkg::PLL_DIV_FIVE, 2'b01});
      wr(5'h02, 8'h0C);
      chk({9'h000, ctrl.highpass_off, ctrl.pll_final_div, ctrl.analog_loopback,
         ctrl.bitstream_loopback}, {9'h000, 1'b0, vccr_pkg::PLL_DIV_TEN, 2'b10});
      $display("test filter_loopback done");

      wr(5'h03, 8'h08);
      wr(5'h04, 8'hFF);
      chk({7'h00, ctrl.pll_divider_value}, 16'h0009);
      chk({7'h00, ctrl.pll_multiplier_value}, 16'h0100);
      wr(5'h03, 8'h00);
      chk({15'h0000, ctrl.pll_bypass}, 16'h0000);
      wr(5'h04, 8'h00);
      chk({15'h0000, ctrl.pll_bypass}, 16'h0001);
      chk({7'h00, ctrl.pll_divider_value}, 16'h0001);
      $display("test pll_values done");

      for (int i = 0; i < 4; i++) begin
         d = {i[1:0], i[0], i[1:0], i[1], i[0], i[1]};
         wr(5'h05, d);
         rd_chk(5'h05, d);
         chk({2'h0, ctrl.line_in_gain_db, ctrl.line_in_mute, ctrl.mic_gain_db, ctrl.mic_mute,
            ctrl.handset_in_mute, ctrl.iir_select}, {2'h0, (i == 3) ? 5'h14 : (i == 2) ? 5'h0A
            : 5'h00, i[0], 5'(i * 10), i[1], i[0], i[1]});
      end
      $display("test input_gain done");

      wr(5'h06, 8'h5D);
      chk({9'h000, ctrl.receive_gain, ctrl.line_out_mute, ctrl.handset_out_mute},
         16'h005E);
      wr(5'h06, 8'hFE, 1'b1);
      rd_chk(5'h06, 8'h7E);
      chk({9'h000, ctrl.receive_gain, ctrl.line_out_mute, ctrl.handset_out_mute},
         16'h007D);
      wr(5'h00, 8'hFF);
      rd_chk(5'h00, 8'h00);
      rd_chk(5'h06, 8'h7E);
      $display("test receive_gain done");

      wr(5'h07, 8'h01);
      chk({9'h000, ctrl.transmit_gain, ctrl.left_speaker_mute, ctrl.right_speaker_mute},
         16'h0002);
      wr(5'h09, 8'hFF, 1'b1);
      rd_chk(5'h09, 8'h0F);
      chk({14'h0000, ctrl.line_out_atten}, 16'h0003);
      wr(5'h01, 8'h1F);
      wr(5'h01, 8'h80);
      check_defaults();
      $display("test soft_reset done");
      end_of_test();
   end
endmodule // vccr_bank_test
